// File: rtl/bor_ctl_defines.vh
// Constants for the brown-out and power-up reset controller.
// Assumes inclusion by bor_ctl.v only; plain Verilog-2005 macros.
//
// Functional notes
// - All reset sources OR together into one core reset hold.
// - Core stays in reset while supply is below the power-on level.
// - Enabled power-up delay lasts nominally 64 ms after power-on or brown-out.
// - Core stays in reset for the whole power-up delay count.
// - Power-up delay runs only when its active-low enable bit is clear.
// - Power-up delay starts after power-on and brown-out holds both release.
// - One configuration bit picks between two brown-out trip levels.
// - Supply-level brown-out trips only when supply stays low past the filter duration.
// - Mode 11: detection always on; start-up waits for ready and good supply.
// - Mode 11: protection active in sleep; wake-up is not delayed.
// - Mode 10: detection on while awake, off in sleep; start-up waits.
// - Mode 10: wake-up from sleep waits until the detector is ready.
// - Mode 01: software bit switches detection; start-up does not wait.
// - Mode 01: protection starts once ready and ignores sleep.
// - Mode 00: detection off; execution starts without waiting for detector.
// - Software enable bit 7 always read/write; acts only in mode 01.
// - Fast-start bit 6 read/write; forces band-gap on only in modes 10, 01.
// - Bit 0 reads detector ready; bits 5 to 1 read zero.
// - Execution waits for power-up timer, oscillator timer and reset pin.
// - Low-power brown-out request ORs into the brown-out reset.
`ifndef BOR_CTL_DEFINES_VH
`define BOR_CTL_DEFINES_VH

// Register map
`define BOR_CTL_ADDR_CONTROL   8'h00
// Control register fields
`define BOR_CTL_BIT_SW_EN      7
`define BOR_CTL_BIT_FAST       6
`define BOR_CTL_BIT_READY      0
`define BOR_CTL_RST_SW_EN      1'b1
`define BOR_CTL_RST_FAST       1'b0
// Mode field codes
`define BOR_CTL_MODE_ON        2'b11
`define BOR_CTL_MODE_AWAKE     2'b10
`define BOR_CTL_MODE_SW        2'b01
`define BOR_CTL_MODE_OFF       2'b00
// Timing
`define BOR_CTL_CLK_HZ         25000000
`define BOR_CTL_DELAY_MS       64
`define BOR_CTL_DELAY_CYC      ((`BOR_CTL_CLK_HZ / 1000) * `BOR_CTL_DELAY_MS)
`define BOR_CTL_FILTER_NS      1000
`define BOR_CTL_FILTER_CYC     ((`BOR_CTL_FILTER_NS * 25 + 999) / 1000)
`define BOR_CTL_READY_NS       2000
`define BOR_CTL_READY_CYC      ((`BOR_CTL_READY_NS * 25 + 999) / 1000)

`endif

// File: rtl/bor_ctl.v
// Brown-out, power-on and power-up delay reset controller with AHB-Lite control register.
// Assumes analog comparator flags arrive asynchronously; all else synchronous to REF_CLK_IN.
`include "bor_ctl_defines.vh"

module bor_ctl #(
    parameter DELAY_CYC  = `BOR_CTL_DELAY_CYC,
    parameter FILTER_CYC = `BOR_CTL_FILTER_CYC,
    parameter READY_CYC  = `BOR_CTL_READY_CYC
) (
    // Clock and reset
    input  wire        REF_CLK_IN,
    input  wire        RESET_IN,
    // AHB-Lite slave
    input  wire        HSEL_IN,
    input  wire [31:0] HADDR_IN,
    input  wire [1:0]  HTRANS_IN,
    input  wire        HWRITE_IN,
    input  wire [2:0]  HSIZE_IN,
    input  wire [31:0] HWDATA_IN,
    input  wire        HREADY_IN,
    output wire [31:0] HRDATA_OUT,
    output wire        HREADYOUT_OUT,
    output wire        HRESP_OUT,
    // Analog detector indications
    input  wire        SUPPLY_ABOVE_POR_IN,
    input  wire        SUPPLY_BELOW_LEVEL_A_IN,
    input  wire        SUPPLY_BELOW_LEVEL_B_IN,
    input  wire        LOW_POWER_BROWNOUT_RESET_IN,
    // Configuration bits
    input  wire [1:0]  BROWNOUT_MODE_FIELD_IN,
    input  wire        BROWNOUT_LEVEL_SELECT_IN,
    input  wire        POWER_UP_DELAY_ENABLE_N_IN,
    // Other reset sources, active high; OSC_STARTUP_DONE_IN is a done flag that holds reset while low
    input  wire        EXTERNAL_RESET_PIN_IN,
    input  wire        WATCHDOG_RESET_SOURCE_IN,
    input  wire        RESET_INSTRUCTION_IN,
    input  wire        STACK_OVERFLOW_IN,
    input  wire        STACK_UNDERFLOW_IN,
    input  wire        PROG_MODE_EXIT_IN,
    input  wire        OSC_STARTUP_DONE_IN,
    // Power state
    input  wire        SLEEP_IN,
    // Outputs
    output reg         CORE_RESET_OUT,
    output reg         BROWNOUT_RESET_OUT,
    output reg         DETECTOR_ENABLE_OUT,
    output reg         BANDGAP_FORCE_ON_OUT,
    output reg         WAKE_HOLD_OUT
);

    // Sequencer states
    localparam [2:0] ST_HOLD  = 3'b001;
    localparam [2:0] ST_DELAY = 3'b010;
    localparam [2:0] ST_RUN   = 3'b100;

    reg  [1:0]  por_sync_reg;
    reg  [1:0]  low_sync_reg;
    reg  [1:0]  lp_sync_reg;
    reg  [2:0]  state_reg;
    reg  [2:0]  state_next;
    reg  [31:0] delay_cnt_reg;
    reg  [31:0] delay_cnt_next;
    reg  [15:0] filter_cnt_reg;
    reg  [15:0] ready_cnt_reg;
    reg         ready_reg;
    reg         bor_trip_reg;
    reg         sw_en_reg;
    reg         fast_reg;
    reg         dphase_reg;
    reg         dwrite_reg;
    reg         dsel_reg;
    reg  [31:0] rdata_reg;
    reg         det_on;
    reg         startup_wait;
    wire        supply_low;
    wire        supply_ok;
    wire        low_sel;
    wire        lp_req;
    wire        bor_any;
    wire        addr_take;
    wire        other_rst;

    // Mode needing start-up wait for detector
    function waits_for_ready;
        input [1:0] mode;
        begin
            waits_for_ready = (mode == `BOR_CTL_MODE_ON) || (mode == `BOR_CTL_MODE_AWAKE);
        end
    endfunction

    // Analog threshold synchronisers
    assign low_sel = BROWNOUT_LEVEL_SELECT_IN ? SUPPLY_BELOW_LEVEL_B_IN
                                              : SUPPLY_BELOW_LEVEL_A_IN;
    always @(posedge REF_CLK_IN) begin
        if (RESET_IN) begin
            por_sync_reg <= 2'b00;
            low_sync_reg <= 2'b11;
            lp_sync_reg  <= 2'b00;
        end else begin
            por_sync_reg <= {por_sync_reg[0], SUPPLY_ABOVE_POR_IN};
            low_sync_reg <= {low_sync_reg[0], low_sel};
            lp_sync_reg  <= {lp_sync_reg[0], LOW_POWER_BROWNOUT_RESET_IN};
        end
    end
    assign supply_ok  = por_sync_reg[1];
    assign supply_low = low_sync_reg[1];
    assign lp_req     = lp_sync_reg[1];

    // Detector enable per mode
    always @* begin
        case (BROWNOUT_MODE_FIELD_IN)
            `BOR_CTL_MODE_ON:    det_on = 1'b1;
            `BOR_CTL_MODE_AWAKE: det_on = ~SLEEP_IN;
            `BOR_CTL_MODE_SW:    det_on = sw_en_reg;
            default:             det_on = 1'b0;
        endcase
    end

    // Detector warm-up, sleep ignored except through det_on
    always @(posedge REF_CLK_IN) begin
        if (RESET_IN) begin
            ready_cnt_reg <= 16'h0000;
            ready_reg     <= 1'b0;
        end else if (!det_on) begin
            ready_cnt_reg <= 16'h0000;
            ready_reg     <= 1'b0;
        end else if (ready_cnt_reg >= READY_CYC[15:0] - 16'h0001) begin
            ready_reg     <= 1'b1;
        end else begin
            ready_cnt_reg <= ready_cnt_reg + 16'h0001;
        end
    end

    // Noise filter on the low-supply flag
    always @(posedge REF_CLK_IN) begin
        if (RESET_IN) begin
            filter_cnt_reg <= 16'h0000;
            bor_trip_reg   <= 1'b0;
        end else if (!(ready_reg && supply_low)) begin
            filter_cnt_reg <= 16'h0000;
            bor_trip_reg   <= 1'b0;
        end else if (filter_cnt_reg >= FILTER_CYC[15:0]) begin
            bor_trip_reg   <= 1'b1;
        end else begin
            filter_cnt_reg <= filter_cnt_reg + 16'h0001;
        end
    end
    assign bor_any = bor_trip_reg | lp_req;

    // Start-up wait for ready and good supply in modes 11 and 10
    always @* begin
        if (waits_for_ready(BROWNOUT_MODE_FIELD_IN))
            startup_wait = ~ready_reg | supply_low;
        else
            startup_wait = 1'b0;
    end

    // Power-on, brown-out and delay sequencer
    always @* begin
        state_next     = state_reg;
        delay_cnt_next = delay_cnt_reg;
        case (state_reg)
            ST_HOLD: begin
                delay_cnt_next = 32'h0000_0000;
                if (supply_ok && !bor_any && !startup_wait) begin
                    if (POWER_UP_DELAY_ENABLE_N_IN)
                        state_next = ST_RUN;
                    else
                        state_next = ST_DELAY;
                end
            end
            ST_DELAY: begin
                if (!supply_ok || bor_any)
                    state_next = ST_HOLD;
                else if (delay_cnt_reg >= DELAY_CYC - 1)
                    state_next = ST_RUN;
                else
                    delay_cnt_next = delay_cnt_reg + 32'h0000_0001;
            end
            ST_RUN: begin
                if (!supply_ok || bor_any)
                    state_next = ST_HOLD;
            end
            default: state_next = ST_HOLD;
        endcase
    end

    always @(posedge REF_CLK_IN) begin
        if (RESET_IN) begin
            state_reg     <= ST_HOLD;
            delay_cnt_reg <= 32'h0000_0000;
        end else begin
            state_reg     <= state_next;
            delay_cnt_reg <= delay_cnt_next;
        end
    end

    // Merge of all reset sources
    assign other_rst = EXTERNAL_RESET_PIN_IN | WATCHDOG_RESET_SOURCE_IN | RESET_INSTRUCTION_IN
                     | STACK_OVERFLOW_IN | STACK_UNDERFLOW_IN | PROG_MODE_EXIT_IN;
    always @(posedge REF_CLK_IN) begin
        if (RESET_IN) begin
            CORE_RESET_OUT       <= 1'b1;
            BROWNOUT_RESET_OUT   <= 1'b0;
            DETECTOR_ENABLE_OUT  <= 1'b0;
            BANDGAP_FORCE_ON_OUT <= 1'b0;
            WAKE_HOLD_OUT        <= 1'b0;
        end else begin
            CORE_RESET_OUT       <= (state_next != ST_RUN)
                                  | !OSC_STARTUP_DONE_IN | other_rst;
            BROWNOUT_RESET_OUT   <= bor_any;
            DETECTOR_ENABLE_OUT  <= det_on;
            BANDGAP_FORCE_ON_OUT <= fast_reg
                && (BROWNOUT_MODE_FIELD_IN == `BOR_CTL_MODE_AWAKE
                    || BROWNOUT_MODE_FIELD_IN == `BOR_CTL_MODE_SW);
            WAKE_HOLD_OUT        <= (BROWNOUT_MODE_FIELD_IN == `BOR_CTL_MODE_AWAKE)
                                  && !ready_reg && !SLEEP_IN;
        end
    end

    // AHB-Lite address phase capture
    assign addr_take = HSEL_IN & HREADY_IN & HTRANS_IN[1];
    always @(posedge REF_CLK_IN) begin
        if (RESET_IN) begin
            dphase_reg <= 1'b0;
            dwrite_reg <= 1'b0;
            dsel_reg   <= 1'b0;
        end else if (HREADY_IN) begin
            dphase_reg <= addr_take;
            dwrite_reg <= addr_take & HWRITE_IN;
            dsel_reg   <= addr_take & (HADDR_IN[7:0] == `BOR_CTL_ADDR_CONTROL);
        end
    end

    // Control register write
    always @(posedge REF_CLK_IN) begin
        if (RESET_IN) begin
            sw_en_reg <= `BOR_CTL_RST_SW_EN;
            fast_reg  <= `BOR_CTL_RST_FAST;
        end else if (dphase_reg && dwrite_reg && dsel_reg) begin
            sw_en_reg <= HWDATA_IN[`BOR_CTL_BIT_SW_EN];
            fast_reg  <= HWDATA_IN[`BOR_CTL_BIT_FAST];
        end
    end

    // Read data prepared at address phase
    always @(posedge REF_CLK_IN) begin
        if (RESET_IN)
            rdata_reg <= 32'h0000_0000;
        else if (addr_take && !HWRITE_IN && HADDR_IN[7:0] == `BOR_CTL_ADDR_CONTROL)
            rdata_reg <= {24'h00_0000, sw_en_reg, fast_reg, 5'h00, ready_reg};
        else if (HREADY_IN)
            rdata_reg <= 32'h0000_0000;
    end

    assign HRDATA_OUT    = rdata_reg;
    assign HREADYOUT_OUT = 1'b1;
    assign HRESP_OUT     = 1'b0;

endmodule

// File: test/brc_monitor.sv
// Port checker for the reset controller.
// Assumes a bind onto bor_ctl; everything on REF_CLK_IN.
module brc_monitor #(
    parameter DELAY_CYC = 20
) (
    input wire logic        REF_CLK_IN,
    input wire logic        RESET_IN,
    input wire logic        SUPPLY_ABOVE_POR_IN,
    input wire logic        SUPPLY_BELOW_LEVEL_A_IN,
    input wire logic        SUPPLY_BELOW_LEVEL_B_IN,
    input wire logic        LOW_POWER_BROWNOUT_RESET_IN,
    input wire logic [1:0]  BROWNOUT_MODE_FIELD_IN,
    input wire logic        BROWNOUT_LEVEL_SELECT_IN,
    input wire logic        POWER_UP_DELAY_ENABLE_N_IN,
    input wire logic        WATCHDOG_RESET_SOURCE_IN,
    input wire logic [31:0] HRDATA_OUT,
    input wire logic        CORE_RESET_OUT,
    input wire logic        BROWNOUT_RESET_OUT,
    input wire logic        DETECTOR_ENABLE_OUT,
    input wire logic        BANDGAP_FORCE_ON_OUT,
    input wire logic        WAKE_HOLD_OUT
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (RESET_IN);
    logic [1:0]  m;
    logic        lo;
    logic        lp;
    logic [31:0] good_cnt;
    // Mode and selected trip level
    assign m  = BROWNOUT_MODE_FIELD_IN;
    assign lp = LOW_POWER_BROWNOUT_RESET_IN;
    assign lo = BROWNOUT_LEVEL_SELECT_IN ? SUPPLY_BELOW_LEVEL_B_IN : SUPPLY_BELOW_LEVEL_A_IN;
    // Cycles of good supply; large after reset as the history is unknown
    always @(posedge REF_CLK_IN) begin
        if (RESET_IN) begin
            good_cnt <= 32'h0001_0000;
        end else if (!SUPPLY_ABOVE_POR_IN) begin
            good_cnt <= 32'h0;
        end else begin
            good_cnt <= good_cnt + 32'h1;
        end
    end
    a_por_holds_core: assert property (
        !SUPPLY_ABOVE_POR_IN [*4] |=> CORE_RESET_OUT) else $error("core not held");
    a_source_to_core: assert property (
        WATCHDOG_RESET_SOURCE_IN |=> CORE_RESET_OUT) else $error("source ignored");
    a_delay_runs_full: assert property (
        $fell(CORE_RESET_OUT) && !POWER_UP_DELAY_ENABLE_N_IN |-> good_cnt >= DELAY_CYC)
        else $error("delay cut short");
    a_lp_trips_out: assert property (
        lp [*3] |=> BROWNOUT_RESET_OUT) else $error("low power request lost");
    a_short_dip_ignored: assert property (
        (!lo && !lp) [*4] ##1 (lo && !lp) [*2] ##1 (!lo && !lp) [*4] |-> !BROWNOUT_RESET_OUT)
        else $error("short dip tripped");
    a_long_dip_trips: assert property (
        DETECTOR_ENABLE_OUT [*8] ##1 (DETECTOR_ENABLE_OUT && lo
        && $stable(BROWNOUT_LEVEL_SELECT_IN)) [*8] |=> BROWNOUT_RESET_OUT)
        else $error("long dip missed");
    a_gap_off_modes: assert property (
        (m == 2'h0 || m == 2'h3) [*2] |-> !BANDGAP_FORCE_ON_OUT) else $error("band gap forced");
    a_off_mode_idle: assert property (
        (m == 2'h0) [*2] |-> !DETECTOR_ENABLE_OUT) else $error("detector on in off mode");
    a_on_mode_awake: assert property (
        (m == 2'h3) [*3] |-> DETECTOR_ENABLE_OUT && !WAKE_HOLD_OUT) else $error("on mode wrong");
    a_unused_read_zero: assert property (
        HRDATA_OUT[31:8] == 24'h0 && HRDATA_OUT[5:1] == 5'h0) else $error("unused bits set");
    c_release: cover property ($fell(CORE_RESET_OUT));
    c_trip: cover property ($rose(BROWNOUT_RESET_OUT));
    c_wake: cover property ($rose(WAKE_HOLD_OUT));
endmodule

bind bor_ctl brc_monitor #(.DELAY_CYC(DELAY_CYC)) u_brc_monitor (
    .REF_CLK_IN(REF_CLK_IN), .RESET_IN(RESET_IN), .SUPPLY_ABOVE_POR_IN(SUPPLY_ABOVE_POR_IN),
    .SUPPLY_BELOW_LEVEL_A_IN(SUPPLY_BELOW_LEVEL_A_IN),
    .SUPPLY_BELOW_LEVEL_B_IN(SUPPLY_BELOW_LEVEL_B_IN),
    .LOW_POWER_BROWNOUT_RESET_IN(LOW_POWER_BROWNOUT_RESET_IN),
    .BROWNOUT_MODE_FIELD_IN(BROWNOUT_MODE_FIELD_IN),
    .BROWNOUT_LEVEL_SELECT_IN(BROWNOUT_LEVEL_SELECT_IN),
    .POWER_UP_DELAY_ENABLE_N_IN(POWER_UP_DELAY_ENABLE_N_IN),
    .WATCHDOG_RESET_SOURCE_IN(WATCHDOG_RESET_SOURCE_IN), .HRDATA_OUT(HRDATA_OUT),
    .CORE_RESET_OUT(CORE_RESET_OUT), .BROWNOUT_RESET_OUT(BROWNOUT_RESET_OUT),
    .DETECTOR_ENABLE_OUT(DETECTOR_ENABLE_OUT), .BANDGAP_FORCE_ON_OUT(BANDGAP_FORCE_ON_OUT),
    .WAKE_HOLD_OUT(WAKE_HOLD_OUT));

// File: test/brc_tb_top.sv
// Self-checking bench for the reset controller.
// Assumes short test counts: delay 20, filter 3, ready 4.
module brc_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hrdy, hresp;
    logic [1:0] htrans = 2'h0, mode = 2'h3;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic por_ok = 1'b1, bel_a = 1'b0, bel_b = 1'b0, lp_req = 1'b0, lvl = 1'b0;
    logic dly_n = 1'b0, osc = 1'b1, sleep = 1'b0, core, bo, den, gap, wake;
    logic [5:0] src = 6'h0;
    int fails = 0, n_compared = 0;
    bor_ctl #(.DELAY_CYC(20), .FILTER_CYC(3), .READY_CYC(4)) u_bor_ctl (
        .REF_CLK_IN(clk), .RESET_IN(rst), .HSEL_IN(hsel), .HADDR_IN(haddr),
        .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
        .HREADY_IN(hrdy), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hrdy), .HRESP_OUT(hresp),
        .SUPPLY_ABOVE_POR_IN(por_ok), .SUPPLY_BELOW_LEVEL_A_IN(bel_a),
        .SUPPLY_BELOW_LEVEL_B_IN(bel_b), .LOW_POWER_BROWNOUT_RESET_IN(lp_req),
        .BROWNOUT_MODE_FIELD_IN(mode), .BROWNOUT_LEVEL_SELECT_IN(lvl),
        .POWER_UP_DELAY_ENABLE_N_IN(dly_n), .EXTERNAL_RESET_PIN_IN(src[0]),
        .WATCHDOG_RESET_SOURCE_IN(src[1]), .RESET_INSTRUCTION_IN(src[2]),
        .STACK_OVERFLOW_IN(src[3]), .STACK_UNDERFLOW_IN(src[4]), .PROG_MODE_EXIT_IN(src[5]),
        .OSC_STARTUP_DONE_IN(osc), .SLEEP_IN(sleep), .CORE_RESET_OUT(core),
        .BROWNOUT_RESET_OUT(bo), .DETECTOR_ENABLE_OUT(den), .BANDGAP_FORCE_ON_OUT(gap),
        .WAKE_HOLD_OUT(wake));
    // Clock, 40 ns period
    initial begin
        forever #20 clk = ~clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One single-word transfer; entered just after an edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk); while (hrdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hrdy !== 1'b1);
        r = hrdata;
    endtask
    task automatic t_regs;
        logic [31:0] r;
        bus(1'b0, 8'h00, 32'h0, r);
        chk(r, 32'h81);
        chk(hresp, 1'b0);
        bus(1'b1, 8'h00, 32'hFF, r);
        bus(1'b1, 8'h04, 32'hFF, r);
        bus(1'b0, 8'h04, 32'h0, r);
        chk(r, 32'h0);
        bus(1'b0, 8'h00, 32'h0, r);
        chk(r, 32'hC1);
    endtask
    task automatic t_modes;
        logic [31:0] r;
        logic [1:0] exp [4] = '{2'b00, 2'b11, 2'b11, 2'b01};
        for (int i = 0; i < 4; i++) begin
            mode <= i[1:0];
            cyc(4);
            chk({gap, den}, exp[i]);
        end
        bus(1'b1, 8'h00, 32'h40, r);
        mode <= 2'h1;
        cyc(4);
        chk(den, 1'b0);
        mode <= 2'h0;
        cyc(4);
        bus(1'b0, 8'h00, 32'h0, r);
        chk(r, 32'h40);
    endtask
    task automatic t_sleep;
        logic [31:0] r;
        mode <= 2'h2;
        sleep <= 1'b1;
        cyc(4);
        chk(den, 1'b0);
        sleep <= 1'b0;
        cyc(2);
        chk(wake, 1'b1);
        cyc(10);
        chk(wake, 1'b0);
        mode <= 2'h3;
        sleep <= 1'b1;
        cyc(4);
        chk(den, 1'b1);
        sleep <= 1'b0;
        cyc(2);
        chk(wake, 1'b0);
        bus(1'b1, 8'h00, 32'h80, r);
        mode <= 2'h1;
        sleep <= 1'b1;
        cyc(4);
        chk(den, 1'b1);
        sleep <= 1'b0;
    endtask
    task automatic t_delay;
        int n;
        mode <= 2'h0;
        por_ok <= 1'b0;
        cyc(5);
        chk(core, 1'b1);
        por_ok <= 1'b1;
        n = 0;
        while (core !== 1'b0 && n < 100) begin
            @(posedge clk);
            n++;
        end
        chk(n >= 20 && n <= 26, 1'b1);
        dly_n <= 1'b1;
        por_ok <= 1'b0;
        cyc(5);
        por_ok <= 1'b1;
        cyc(6);
        chk(core, 1'b0);
        osc <= 1'b0;
        cyc(3);
        chk(core, 1'b1);
        osc <= 1'b1;
        cyc(3);
        chk(core, 1'b0);
        dly_n <= 1'b0;
    endtask
    task automatic t_trip;
        mode <= 2'h3;
        bel_b <= 1'b1;
        cyc(12);
        chk(bo, 1'b0);
        bel_b <= 1'b0;
        bel_a <= 1'b1;
        cyc(2);
        bel_a <= 1'b0;
        cyc(8);
        chk(bo, 1'b0);
        bel_a <= 1'b1;
        cyc(12);
        chk({bo, core}, 2'b11);
        bel_a <= 1'b0;
        lvl <= 1'b1;
        bel_b <= 1'b1;
        cyc(12);
        chk(bo, 1'b1);
        bel_b <= 1'b0;
        lvl <= 1'b0;
        lp_req <= 1'b1;
        cyc(6);
        chk(bo, 1'b1);
        lp_req <= 1'b0;
        cyc(15);
        chk(core, 1'b1);
        cyc(25);
        chk(core, 1'b0);
    endtask
    task automatic t_sources;
        for (int i = 0; i < 6; i++) begin
            src <= 6'h1 << i;
            cyc(2);
            chk(core, 1'b1);
            src <= 6'h0;
            cyc(3);
            chk(core, 1'b0);
        end
    endtask
    task automatic stop_test;
        $display("compared=%0d failed=%0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        cyc(40);
        t_regs;
        t_modes;
        t_sleep;
        t_delay;
        t_trip;
        t_sources;
        stop_test;
    end
    // Watchdog, far beyond the expected run
    initial begin
        #200000;
        fails++;
        stop_test;
    end
endmodule
